// *** spm_board_model.sv ***
// board side of the pads: drive, weak pulls, floating lines
`timescale 1ns/1ps
module spm_board_model (
   // pad drive from the block
   input logic i_ref_clk,
   input logic [31:0] i_out,
   input logic [31:0] i_oe,
   input logic [31:0] i_pu,
   input logic [31:0] i_pd,
   // level seen on each pad
   output logic [31:0] o_level
);
   logic [31:0] last = 32'h0;
   // a floating pad toggles so it never looks like a stable value
   assign o_level = (i_oe & i_out) | (~i_oe & i_pu) | (~i_oe & ~i_pu & ~i_pd & ~last);
   always @(posedge i_ref_clk) begin
      last <= o_level;
   end
endmodule

// *** spm_consts.vh ***
// register map, field positions, reset values for the shared pin function mux
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
// register byte offsets
`define SPM_OFS_PIO_ENABLE 8'h00
`define SPM_OFS_PIO_DIR 8'h04
`define SPM_OFS_PIO_PULL 8'h08
`define SPM_OFS_PIO_DATA 8'h0C
`define SPM_OFS_PIO_PIN 8'h10
`define SPM_OFS_AUX_CONFIG 8'h14
`define SPM_OFS_SEL_AUX 8'h18
`define SPM_OFS_PERIPH_BASE 8'h1C
`define SPM_OFS_STATUS 8'h20
// aux_config_reg fields
`define SPM_AUX_FLOW_SEL 0
`define SPM_AUX_FLOW_CTRL_ENABLE 1
// select aux fields
`define SPM_SEL_EXPAND 0
`define SPM_SEL_MEM_SPACE 1
// reset values: bits 4..9 normal function, 1 and 10 pulldown
`define SPM_RST_PIO_ENABLE 32'hFFFFFC0F
`define SPM_RST_PIO_DIR 32'h00000000
`define SPM_RST_PIO_PULL 32'hFFFFFBBD
`define SPM_RST_AUX_CONFIG 32'h00000000
`define SPM_RST_SEL_AUX 32'h00000001
`define SPM_RST_PERIPH_BASE 32'h00000000
// pins handed back to normal function when the strap is low
`define SPM_STRAP_EMU_MASK 32'h24000380
// pull bits fixed by hardware: 4,5,7,8,9 pullup only, 6 pulldown only
`define SPM_PULL_FIXED_MASK 32'h000003F0
`define SPM_PULL_FIXED_VAL 32'h000003B0
// pad numbers that this block drives itself
`define SPM_PAD_SEL6 2
`define SPM_PAD_SEL5 3
`define SPM_PAD_SEL0 16
`define SPM_PAD_SEL1 17
`define SPM_PAD_SEL2 18
`define SPM_PAD_SEL3 19
// peripheral block geometry
`define SPM_REGION_BITS 8
`define SPM_NUM_SELECTS 7
`endif

// *** spm_periph_decode.v ***
// combinational peripheral region decoder, one-hot active high
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_periph_decode #(
   parameter ADDR_W = 20
) (
   // bus address
   input wire [ADDR_W-1:0] i_addr,
   input wire i_io_space,
   // configuration
   input wire [ADDR_W-12:0] i_base,
   input wire i_mem_space,
   // decode result
   output reg [`SPM_NUM_SELECTS-1:0] o_hit
);
   // 256-byte regions above a 2 KB aligned base; region 7 has no select
   always @* begin
      o_hit = {`SPM_NUM_SELECTS{1'b0}};
      if ((i_io_space != i_mem_space) && (i_addr[ADDR_W-1:11] == i_base) &&
          (i_addr[10:8] != 3'h7)) begin
         o_hit[i_addr[10:8]] = 1'b1;
      end
   end
endmodule

// *** spm_pin_mux.v ***
// shared pin function mux with programmable io pins and apb registers
// Notes on behaviour
// - periph_select_3 owns pin unless flow control on
// - periph_select_3 high in hold and reset
// - peripheral selects assert with address phase
// - each select decodes 256 bytes above base
// - flow select 1 gives send request
// - send request active while tx pending
// - flow select 0 gives receive ready
// - receive ready active while rx empty
// - select 5 region five, select 6 six
// - select 6 high in hold and reset
// - expand bit 0 gives latched address bits
// - latched address bits hold value in hold
// - 32 pins: enable, direction, pull each
// - pins 1,10 pulldown; 4-9 normal; rest pullup
// - address, direction, enable, ready pins normal
// - low strap returns emulator pins to normal
// - fixed pull option on pins 4 to 9
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_pin_mux #(
   parameter NPINS = 32,
   parameter ADDR_W = 20
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_rst_b,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // processor bus cycle
   input wire [ADDR_W-1:0] i_bus_addr,
   input wire i_addr_phase,
   input wire i_cycle_end,
   input wire i_bus_io,
   input wire i_bus_hold,
   // serial port 1 state
   input wire i_port1_tx_pending,
   input wire i_port1_rx_full,
   // emulator strap, sampled after reset release
   input wire i_addr_strap_b,
   // normal peripheral functions per pad
   input wire [NPINS-1:0] i_func_out,
   input wire [NPINS-1:0] i_func_oe,
   // pads
   input wire [NPINS-1:0] i_pad_in,
   output reg [NPINS-1:0] o_pad_out,
   output reg [NPINS-1:0] o_pad_oe,
   output reg [NPINS-1:0] o_pad_pullup,
   output reg [NPINS-1:0] o_pad_pulldown,
   output reg [NPINS-1:0] o_func_in
);
   // software registers
   reg [NPINS-1:0] pio_enable;
   reg [NPINS-1:0] pio_dir;
   reg [NPINS-1:0] pio_pull;
   reg [NPINS-1:0] pio_data;
   reg [NPINS-1:0] pio_pin;
   reg [1:0] aux_config_reg;
   reg [1:0] sel_aux;
   reg [ADDR_W-12:0] periph_base;
   reg strap_done;
   reg strap_low;
   // bus cycle state
   reg [`SPM_NUM_SELECTS-1:0] periph_selects;
   reg latched_addr_bit1;
   reg latched_addr_bit2;
   wire [`SPM_NUM_SELECTS-1:0] dec_hit;
   // combinational next values
   reg [NPINS-1:0] next_pad_out;
   reg [NPINS-1:0] next_pad_oe;
   reg [NPINS-1:0] next_pad_pullup;
   reg [NPINS-1:0] next_pad_pulldown;
   reg [NPINS-1:0] fn_out;
   reg [NPINS-1:0] fn_oe;
   reg [31:0] next_rdata;
   reg next_err;
   integer k;

   wire flow_ctrl_enable = aux_config_reg[`SPM_AUX_FLOW_CTRL_ENABLE];
   wire flow_sel = aux_config_reg[`SPM_AUX_FLOW_SEL];
   wire select_expand_bit = sel_aux[`SPM_SEL_EXPAND];
   wire apb_setup = i_psel && i_penable && !o_pready;
   wire apb_done = i_psel && i_penable && o_pready;
   wire apb_wr = apb_done && i_pwrite && !o_pslverr;

   // pull bits of pins 4..9 are tied to their only option
   function [NPINS-1:0] fix_pull;
      input [NPINS-1:0] raw;
      begin
         fix_pull = (raw & ~`SPM_PULL_FIXED_MASK) | `SPM_PULL_FIXED_VAL;
      end
   endfunction

   // chip select level: forced high in hold so an idle bus never selects
   function sel_level;
      input hit;
      input hold;
      begin
         sel_level = hold | ~hit;
      end
   endfunction

   spm_periph_decode #(
      .ADDR_W(ADDR_W)
   ) u_decode (
      .i_addr(i_bus_addr),
      .i_io_space(i_bus_io),
      .i_base(periph_base),
      .i_mem_space(sel_aux[`SPM_SEL_MEM_SPACE]),
      .o_hit(dec_hit)
   );

   // selects latch on the address strobe and hold to cycle end
   always @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         periph_selects <= {`SPM_NUM_SELECTS{1'b0}};
         latched_addr_bit1 <= 1'b0;
         latched_addr_bit2 <= 1'b0;
      end else if (i_bus_hold) begin
         periph_selects <= {`SPM_NUM_SELECTS{1'b0}}; // latched bits kept
      end else if (i_addr_phase) begin
         periph_selects <= dec_hit;
         latched_addr_bit1 <= i_bus_addr[1];
         latched_addr_bit2 <= i_bus_addr[2];
      end else if (i_cycle_end) begin
         periph_selects <= {`SPM_NUM_SELECTS{1'b0}};
      end
   end

   // strap caught once, on the first edge after reset release
   always @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         strap_done <= 1'b0;
         strap_low <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         strap_low <= ~i_addr_strap_b;
      end
   end

   // register writes land on the completing apb edge only
   always @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         pio_enable <= `SPM_RST_PIO_ENABLE;
         pio_dir <= `SPM_RST_PIO_DIR;
         pio_pull <= `SPM_RST_PIO_PULL;
         pio_data <= {NPINS{1'b0}};
         aux_config_reg <= 2'h0;
         sel_aux <= 2'h1;
         periph_base <= {(ADDR_W-11){1'b0}};
      end else begin
         if (strap_done == 1'b0 && !i_addr_strap_b) begin
            pio_enable <= pio_enable & ~`SPM_STRAP_EMU_MASK;
         end else if (apb_wr) begin
            case (i_paddr)
               `SPM_OFS_PIO_ENABLE: pio_enable <= i_pwdata[NPINS-1:0];
               `SPM_OFS_PIO_DIR: pio_dir <= i_pwdata[NPINS-1:0];
               `SPM_OFS_PIO_PULL: pio_pull <= fix_pull(i_pwdata[NPINS-1:0]);
               `SPM_OFS_PIO_DATA: pio_data <= i_pwdata[NPINS-1:0];
               `SPM_OFS_AUX_CONFIG: aux_config_reg <= i_pwdata[1:0];
               `SPM_OFS_SEL_AUX: sel_aux <= i_pwdata[1:0];
               `SPM_OFS_PERIPH_BASE: periph_base <= i_pwdata[ADDR_W-12:0];
               default: pio_data <= pio_data;
            endcase
         end
      end
   end

   // read mux and unmapped detection, sampled in the first access cycle
   always @* begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      case (i_paddr)
         `SPM_OFS_PIO_ENABLE: next_rdata = pio_enable;
         `SPM_OFS_PIO_DIR: next_rdata = pio_dir;
         `SPM_OFS_PIO_PULL: next_rdata = pio_pull;
         `SPM_OFS_PIO_DATA: next_rdata = pio_data;
         `SPM_OFS_PIO_PIN: next_rdata = pio_pin;
         `SPM_OFS_AUX_CONFIG: next_rdata[1:0] = aux_config_reg;
         `SPM_OFS_SEL_AUX: next_rdata[1:0] = sel_aux;
         `SPM_OFS_PERIPH_BASE: next_rdata[ADDR_W-12:0] = periph_base;
         `SPM_OFS_STATUS: next_rdata[2:0] = {i_port1_rx_full, i_port1_tx_pending, strap_low};
         default: next_err = 1'b1;
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else if (apb_setup) begin
         o_pready <= 1'b1;
         o_pslverr <= next_err;
         o_prdata <= i_pwrite ? 32'h00000000 : next_rdata;
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end
   end

   // normal function per pad, with this block's own pins overlaid
   always @* begin
      fn_out = i_func_out;
      fn_oe = i_func_oe;
      fn_out[`SPM_PAD_SEL0] = sel_level(periph_selects[0], i_bus_hold);
      fn_oe[`SPM_PAD_SEL0] = 1'b1;
      fn_out[`SPM_PAD_SEL1] = sel_level(periph_selects[1], i_bus_hold);
      fn_oe[`SPM_PAD_SEL1] = 1'b1;
      // select 2 pad becomes a flow control input when flow control is on
      fn_out[`SPM_PAD_SEL2] = sel_level(periph_selects[2], i_bus_hold);
      fn_oe[`SPM_PAD_SEL2] = ~flow_ctrl_enable;
      fn_oe[`SPM_PAD_SEL3] = 1'b1;
      if (!flow_ctrl_enable) begin
         fn_out[`SPM_PAD_SEL3] = sel_level(periph_selects[3], i_bus_hold);
      end else if (flow_sel) begin
         fn_out[`SPM_PAD_SEL3] = ~i_port1_tx_pending;
      end else begin
         fn_out[`SPM_PAD_SEL3] = i_port1_rx_full;
      end
      fn_oe[`SPM_PAD_SEL5] = 1'b1;
      fn_oe[`SPM_PAD_SEL6] = 1'b1;
      if (select_expand_bit) begin
         fn_out[`SPM_PAD_SEL5] = sel_level(periph_selects[5], i_bus_hold);
         fn_out[`SPM_PAD_SEL6] = sel_level(periph_selects[6], i_bus_hold);
      end else begin
         fn_out[`SPM_PAD_SEL5] = latched_addr_bit1;
         fn_out[`SPM_PAD_SEL6] = latched_addr_bit2;
      end
   end

   // pad drive: programmed pins cut the peripheral off the pad
   always @* begin
      next_pad_out = {NPINS{1'b0}};
      next_pad_oe = {NPINS{1'b0}};
      next_pad_pullup = {NPINS{1'b0}};
      next_pad_pulldown = {NPINS{1'b0}};
      for (k = 0; k < NPINS; k = k + 1) begin
         if (pio_enable[k]) begin
            next_pad_out[k] = pio_data[k];
            next_pad_oe[k] = pio_dir[k];
            next_pad_pullup[k] = ~pio_dir[k] & pio_pull[k];
            next_pad_pulldown[k] = ~pio_dir[k] & ~pio_pull[k];
         end else begin
            next_pad_out[k] = fn_out[k];
            next_pad_oe[k] = fn_oe[k];
         end
      end
   end

   // pads and sampled inputs registered so every output is a flop
   always @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_pad_out <= `SPM_RST_PIO_ENABLE & 32'h000F0000 | 32'h000F000C; // selects high
         o_pad_oe <= 32'h000F000C;
         o_pad_pullup <= 32'h00000000;
         o_pad_pulldown <= 32'h00000000;
         o_func_in <= {NPINS{1'b0}};
         pio_pin <= {NPINS{1'b0}};
      end else begin
         o_pad_out <= next_pad_out;
         o_pad_oe <= next_pad_oe;
         o_pad_pullup <= next_pad_pullup;
         o_pad_pulldown <= next_pad_pulldown;
         // a programmed pin feeds its peripheral an idle high
         o_func_in <= (i_pad_in & ~pio_enable) | pio_enable;
         pio_pin <= i_pad_in;
      end
   end
endmodule

// *** spm_pin_mux_checker.sv ***
// port-level assertions for the shared pin function mux
`timescale 1ns/1ps
module spm_pin_mux_checker (
   // clock, reset and strobes
   input logic i_ref_clk,
   input logic i_rst_b,
   input logic i_psel,
   input logic i_penable,
   input logic i_addr_phase,
   input logic i_cycle_end,
   input logic i_bus_hold,
   // watched outputs
   input logic o_pready,
   input logic [31:0] o_pad_out,
   input logic [31:0] o_pad_oe,
   input logic [31:0] o_pad_pullup,
   input logic [31:0] o_pad_pulldown
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // reset itself is the cause here, so the default disable is lifted
   reset_pads_a: assert property (disable iff (1'h0)
      !i_rst_b ##1 !i_rst_b |-> o_pad_oe == 32'h000F000C && o_pad_out == 32'h000F000C
      && (o_pad_pullup | o_pad_pulldown) == 32'h0) else $error("pads wrong in reset");
   boot_pulls_a: assert property ($rose(i_rst_b) |=>
      o_pad_pullup == 32'hFFFFF80D && o_pad_pulldown == 32'h00000402
      && (o_pad_oe & 32'hFFFFFC0F) == 32'h0) else $error("pulls wrong after reset");
   apb_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("no answer after one wait state");
   hold_high_a: assert property (i_bus_hold [*4] |->
      (o_pad_out & o_pad_oe & 32'h00030000) == (o_pad_oe & 32'h00030000))
      else $error("select low in hold");
   latch_keep_a: assert property (i_bus_hold [*4] |->
      $stable(o_pad_out[3:2])) else $error("shared pads moved in hold");
   select_cause_a: assert property ($fell(o_pad_out[16]) && o_pad_oe[16] &&
      $past(o_pad_oe[16]) |-> $past(i_addr_phase, 2)) else $error("select without cycle");
   select_end_a: assert property (i_cycle_end && !i_addr_phase |-> ##2
      o_pad_out[16] || !o_pad_oe[16]) else $error("select not released");
   pull_fixed_a: assert property (!o_pad_pullup[6] && o_pad_pulldown[9:7] == 3'h0
      && (o_pad_pullup & o_pad_pulldown) == 32'h0) else $error("bad pull option");
endmodule
bind spm_pin_mux spm_pin_mux_checker i_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
   .i_psel(i_psel), .i_penable(i_penable), .i_addr_phase(i_addr_phase),
   .i_cycle_end(i_cycle_end), .i_bus_hold(i_bus_hold), .o_pready(o_pready),
   .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_pad_pullup(o_pad_pullup),
   .o_pad_pulldown(o_pad_pulldown));

// *** spm_pin_mux_tb.sv ***
// self-checking bench for the shared pin function mux
`timescale 1ns/1ps
module spm_pin_mux_tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} spm_row_t;
   logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, ap = 0, ce = 0, io = 1, hold = 0;
   logic v = 0, strap_b = 1, prdy, perr, err;
   logic [7:0] paddr = 8'h00;
   logic [19:0] baddr = 20'h00000;
   logic [31:0] pwd = 32'h0, foe = 32'h0, pin, prd, pout, poe, ppu, ppd, fin, rd;
   logic [31:0] fo = 32'h0;
   int errors = 0;
   int n_checks = 0;
   // reset value of each register except data and pin, last row unmapped
   spm_row_t rows[8] = '{'{8'h00, 32'hFFFFFC0F, 1'h0}, '{8'h04, 32'h0, 1'h0},
      '{8'h08, 32'hFFFFFBBD, 1'h0}, '{8'h14, 32'h0, 1'h0}, '{8'h18, 32'h1, 1'h0},
      '{8'h1C, 32'h0, 1'h0}, '{8'h20, 32'h0, 1'h0}, '{8'h24, 32'h0, 1'h1}};
   // pad pulled low by each region; region 4 has none
   logic [31:0] hits[7] = '{32'h10000, 32'h20000, 32'h40000, 32'h80000, 32'h0, 32'h8, 32'h4};
   spm_pin_mux i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
      .o_pslverr(perr), .i_bus_addr(baddr), .i_addr_phase(ap), .i_cycle_end(ce),
      .i_bus_io(io), .i_bus_hold(hold), .i_port1_tx_pending(v), .i_port1_rx_full(v),
      .i_addr_strap_b(strap_b), .i_func_out(fo), .i_func_oe(foe), .i_pad_in(pin),
      .o_pad_out(pout), .o_pad_oe(poe), .o_pad_pullup(ppu), .o_pad_pulldown(ppd),
      .o_func_in(fin));
   spm_board_model i_board (.i_ref_clk(clk), .i_out(pout), .i_oe(poe), .i_pu(ppu),
      .i_pd(ppd), .o_level(pin));
   always #50 clk = ~clk;
   task automatic report_and_stop;
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk) psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk) pen <= 1'h1;
      do begin
         @(posedge clk);
         if (++n > 20) begin
            errors++;
            report_and_stop();
         end
      end while (prdy !== 1'h1);
      rd = prd;
      err = perr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   // processor cycle: select pads while active and after release
   task automatic cyc(input logic [19:0] a, input logic sp, input logic [31:0] e1, e2);
      @(posedge clk) baddr <= a;
      io <= sp;
      ap <= 1'h1;
      @(posedge clk) ap <= 1'h0;
      @(posedge clk);
      @(negedge clk) chk(pout & 32'h000F000C, e1);
      @(posedge clk) ce <= 1'h1;
      @(posedge clk) ce <= 1'h0;
      @(posedge clk);
      @(negedge clk) chk(pout & 32'h000F000C, e2);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      foreach (rows[i]) begin
         apb(1'h0, rows[i].a, 32'h0);
         chk(rd, rows[i].d);
         chk({31'h0, err}, {31'h0, rows[i].e});
      end
      // hand the select pads back from programmable io
      apb(1'h1, 8'h00, 32'hFFF0FC03);
      for (int n = 0; n < 7; n++)
         cyc({9'h0, n[2:0], 8'hFF}, 1'h1, 32'h000F000C ^ hits[n], 32'h000F000C);
      cyc(20'h0, 1'h0, 32'h000F000C, 32'h000F000C);
      apb(1'h1, 8'h1C, 32'h5);
      apb(1'h1, 8'h18, 32'h3);
      cyc({9'h5, 11'h0}, 1'h0, 32'h000E000C, 32'h000F000C);
      @(posedge clk) hold <= 1'h1;
      cyc({9'h5, 11'h0}, 1'h0, 32'h000F000C, 32'h000F000C);
      @(posedge clk) hold <= 1'h0;
      apb(1'h1, 8'h18, 32'h0);
      cyc(20'h2, 1'h1, 32'h000F0008, 32'h000F0008);
      @(posedge clk) hold <= 1'h1;
      cyc(20'h4, 1'h1, 32'h000F0008, 32'h000F0008);
      @(posedge clk) hold <= 1'h0;
      // every flow setting against both serial port states
      for (int k = 0; k < 8; k++) begin
         apb(1'h1, 8'h14, {30'h0, k[2:1]});
         v <= k[0];
         repeat (3) @(posedge clk);
         // look between edges so the pad flops have settled
         @(negedge clk);
         chk({poe[18], pout[19]}, {!k[2], !k[2] | (k[1] ^ k[0])});
      end
      apb(1'h1, 8'h08, 32'h0);
      apb(1'h0, 8'h08, 32'h0);
      chk(rd, 32'h000003B0);
      apb(1'h1, 8'h08, 32'hFFFFF7FF);
      apb(1'h1, 8'h04, 32'h1);
      apb(1'h1, 8'h0C, 32'h1);
      foe <= 32'hFFFFFFFF;
      // pin 0 function drives low so the programmed high proves the cut
      fo <= 32'hFFFFFFFE;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({poe[4], pout[4], poe[0], pout[0], fin[4], fin[0]}, 6'h3F);
      apb(1'h0, 8'h10, 32'h0);
      chk(rd & 32'h1801, 32'h1001);
      // second power-on with the emulator strap low
      v <= 1'h0;
      strap_b <= 1'h0;
      rst_b <= 1'h0;
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      apb(1'h0, 8'h00, 32'h0);
      chk(rd, 32'hDBFFFC0F);
      apb(1'h0, 8'h20, 32'h0);
      chk(rd, 32'h1);
      report_and_stop();
   end
endmodule
